// >>> rtl/vfl_lookup.sv
// Function
// - A 128-entry VLAN table, indexed by the low 7 VID bits and tagged with the upper 5, yields a 7-bit forwarding domain id.
// - With VLAN enabled, untagged or null-VID frames use the ingress port default VLAN ID.
// - In VLAN mode every decision starts with a VLAN table validity check.
// - An invalid VLAN ID drops the frame and its source is not learned.
// - A valid VLAN ID gives the domain id, which with the DA resolves the destination.
// - No usable static entry and no dynamic hit floods to the VLAN members.
// - No usable static entry but a dynamic hit sends to the dynamic entry port.
// - A static hit with clear domain check flag or matching domain forwards to its ports.
// - A static hit with set flag and other domain is ignored in favour of the dynamic result.
// - Domain id plus SA absent from the dynamic table is written into it.
// - Domain id plus SA already present refreshes that entry time stamp.
// - Per port ingress filtering and non-default-VID discard follow port control bits 6:5.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module vfl_lookup
  import vfl_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic              frm_valid,
  output logic                   frm_ready,
  input  wire logic [2:0]        frm_port,
  input  wire logic              frm_tagged,
  input  wire logic [VID_W-1:0]  frm_vid,
  input  wire logic [MAC_W-1:0]  frm_da,
  input  wire logic [MAC_W-1:0]  frm_sa,
  output logic                   tbl_req,
  output vfl_op_e                tbl_op,
  output logic [MAC_W-1:0]       tbl_mac,
  output logic [FID_W-1:0]       tbl_fid,
  output logic [2:0]             tbl_port,
  input  wire logic              tbl_ack,
  input  wire logic              tbl_hit,
  input  wire logic [NPORT-1:0]  tbl_sta_ports,
  input  wire logic              tbl_sta_use_fid,
  input  wire logic [FID_W-1:0]  tbl_sta_fid,
  input  wire logic [2:0]        tbl_dyn_port,
  output logic                   dec_valid,
  input  wire logic              dec_ready,
  output logic                   dec_drop,
  output logic [NPORT-1:0]       dec_ports
);

  // ==========================================================
  // State
  typedef struct packed {
    vfl_state_e                  st;
    logic                        vlan_en;
    logic [VT_AW-1:0]            vt_idx;
    logic [NPORT-1:0][1:0]       pflt;
    logic [NPORT-1:0][VID_W-1:0] port_default_vlan_id;
    logic [CNT_W-1:0]            fwd_cnt;
    logic [CNT_W-1:0]            drop_cnt;
    logic [2:0]                  port;
    logic [VID_W-1:0]            vid;
    logic [MAC_W-1:0]            da;
    logic [MAC_W-1:0]            sa;
    logic [FID_W-1:0]            forwarding_domain_id;
    logic [NPORT-1:0]            members;
    logic [NPORT-1:0]            sta_ports;
    logic [NPORT-1:0]            ports;
    logic                        sta_ok;
    logic                        drop;
    logic                        learn_new;
    logic                        aw_got;
    logic                        w_got;
    logic [7:0]                  awaddr;
    logic [31:0]                 wdata;
    logic [3:0]                  wstrb;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        rvalid;
    logic [1:0]                  rresp;
    logic [31:0]                 rdata;
  } vfl_state_s;

  vfl_state_s            s_q;
  vfl_state_s            s_d;
  logic [VE_W-1:0]       vtab [VT_DEPTH];
  logic                  vt_we;
  logic [VE_W-1:0]       vt_wdata;
  logic [VE_W-1:0]       vt_e;
  logic [VE_W-1:0]       vt_cur;
  logic                  vt_hit;
  logic                  vt_filt;
  logic [VID_W-1:0]      pv_frm;
  logic [VID_W-1:0]      pv_cur;
  logic [31:0]           wr_word;

  // ==========================================================
  // Helpers
  function automatic logic [NPORT-1:0] onehot(input logic [2:0] p);
    logic [NPORT-1:0] r;
    r = '0;
    if (32'(p) < NPORT)
    begin
      r[p] = 1'b1;
    end
    return r;
  endfunction

  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] b);
    return (a >= b) && (32'(a) < 32'(b) + 4 * NPORT) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] bank_idx(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] o;
    o = a - b;
    return o[4:2];
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a == A_GCTRL || a == A_VT_IDX || a == A_VT_DATA || a == A_STAT
        || in_bank(a, A_PCTRL2) || in_bank(a, A_PORT_DEFAULT_VLAN_ID);
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    if (a == A_GCTRL)
      r[GC_VLAN_EN] = s_q.vlan_en;
    else if (a == A_VT_IDX)
      r[VT_AW-1:0] = s_q.vt_idx;
    else if (a == A_VT_DATA)
      r[VE_W-1:0] = vt_cur;
    else if (a == A_STAT)
      r = {s_q.drop_cnt, s_q.fwd_cnt};
    else if (in_bank(a, A_PCTRL2))
      r[PC_INFILT:PC_NONPVID] = s_q.pflt[bank_idx(a, A_PCTRL2)];
    else if (in_bank(a, A_PORT_DEFAULT_VLAN_ID))
      r[VID_W-1:0] = s_q.port_default_vlan_id[bank_idx(a, A_PORT_DEFAULT_VLAN_ID)];
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // VLAN entry decode
  assign vt_e    = vtab[s_q.vid[VT_AW-1:0]];
  assign vt_cur  = vtab[s_q.vt_idx];
  assign pv_frm  = s_q.port_default_vlan_id[frm_port];
  assign pv_cur  = s_q.port_default_vlan_id[s_q.port];
  // Upper VID bits stored in the entry tell which of the 32 aliases owns it
  assign vt_hit  = vt_e[VE_VALID]
                && (vt_e[VE_W-1:VE_VHI_LSB] == s_q.vid[VID_W-1:VT_AW]);
  assign vt_filt = (s_q.pflt[s_q.port][1] && !vt_e[VE_MEM_LSB + 32'(s_q.port)])
                || (s_q.pflt[s_q.port][0] && (s_q.vid != pv_cur));
  assign wr_word = merge(rd_word(s_q.awaddr), s_q.wdata, s_q.wstrb);

  // ==========================================================
  // Outputs
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign frm_ready     = (s_q.st == S_IDLE);
  assign tbl_req       = (s_q.st == S_STA) || (s_q.st == S_DDA)
                      || (s_q.st == S_DSA) || (s_q.st == S_LRN);
  assign tbl_mac       = (s_q.st == S_DSA || s_q.st == S_LRN) ? s_q.sa : s_q.da;
  assign tbl_fid       = s_q.forwarding_domain_id;
  assign tbl_port      = s_q.port;
  assign dec_valid     = (s_q.st == S_OUT);
  assign dec_drop      = s_q.drop;
  assign dec_ports     = s_q.ports;

  always_comb
  begin
    case (s_q.st)
      S_STA:   tbl_op = OP_STA;
      S_DDA:   tbl_op = OP_DYN_DA;
      S_DSA:   tbl_op = OP_DYN_SA;
      S_LRN:   tbl_op = s_q.learn_new ? OP_LEARN : OP_REFRESH;
      default: tbl_op = OP_STA;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d      = s_q;
    vt_we    = 1'b0;
    vt_wdata = wr_word[VE_W-1:0];
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = addr_ok(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_q.awaddr == A_GCTRL)
        s_d.vlan_en = wr_word[GC_VLAN_EN];
      else if (s_q.awaddr == A_VT_IDX)
        s_d.vt_idx = wr_word[VT_AW-1:0];
      else if (s_q.awaddr == A_VT_DATA)
        vt_we = 1'b1;
      else if (s_q.awaddr == A_STAT)
      begin
        // Any write clears both counters
        s_d.fwd_cnt  = '0;
        s_d.drop_cnt = '0;
      end
      else if (in_bank(s_q.awaddr, A_PCTRL2))
        s_d.pflt[bank_idx(s_q.awaddr, A_PCTRL2)] = wr_word[PC_INFILT:PC_NONPVID];
      else if (in_bank(s_q.awaddr, A_PORT_DEFAULT_VLAN_ID))
        s_d.port_default_vlan_id[bank_idx(s_q.awaddr, A_PORT_DEFAULT_VLAN_ID)] = wr_word[VID_W-1:0];
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = rd_word(s_axi_araddr);
      s_d.rresp  = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    case (s_q.st)
      S_IDLE:
      begin
        if (frm_valid)
        begin
          s_d.port  = frm_port;
          s_d.da    = frm_da;
          s_d.sa    = frm_sa;
          s_d.drop  = 1'b0;
          s_d.ports = '0;
          if (s_q.vlan_en && (!frm_tagged || frm_vid == '0))
            s_d.vid = pv_frm;
          else
            s_d.vid = frm_vid;
          if (s_q.vlan_en)
            s_d.st = S_VLAN;
          else
          begin
            // Plain address mode: one domain, all ports members
            s_d.forwarding_domain_id     = '0;
            s_d.members = '1;
            s_d.st      = S_STA;
          end
        end
      end
      S_VLAN:
      begin
        s_d.forwarding_domain_id     = vt_e[VE_FID_LSB +: FID_W];
        s_d.members = vt_e[VE_MEM_LSB +: NPORT];
        if (!vt_hit || vt_filt)
        begin
          // Skips all table work, so nothing is learned
          s_d.drop = 1'b1;
          s_d.st   = S_OUT;
        end
        else
          s_d.st = S_STA;
      end
      S_STA:
      begin
        if (tbl_ack)
        begin
          s_d.sta_ok    = tbl_hit && (!tbl_sta_use_fid || tbl_sta_fid == s_q.forwarding_domain_id);
          s_d.sta_ports = tbl_sta_ports;
          s_d.st        = S_DDA;
        end
      end
      S_DDA:
      begin
        if (tbl_ack)
        begin
          if (s_q.sta_ok)
            s_d.ports = s_q.sta_ports;
          else if (tbl_hit)
            s_d.ports = onehot(tbl_dyn_port);
          else
            s_d.ports = s_q.members;
          s_d.st = S_DSA;
        end
      end
      S_DSA:
      begin
        if (tbl_ack)
        begin
          s_d.learn_new = !tbl_hit;
          s_d.st        = S_LRN;
        end
      end
      S_LRN:
      begin
        if (tbl_ack)
          s_d.st = S_OUT;
      end
      S_OUT:
      begin
        if (dec_ready)
        begin
          if (s_q.drop)
            s_d.drop_cnt = s_d.drop_cnt + 1'b1;
          else
            s_d.fwd_cnt = s_d.fwd_cnt + 1'b1;
          s_d.st = S_IDLE;
        end
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q         <= '0;
      s_q.st      <= S_IDLE;
      s_q.vlan_en <= VLAN_EN_RST;
      s_q.pflt    <= {NPORT{PFLT_RST}};
      s_q.port_default_vlan_id    <= {NPORT{PORT_DEFAULT_VLAN_ID_RST}};
    end
    else
      s_q <= s_d;
  end

  // Entries reset invalid so a stale VID can never pass
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < VT_DEPTH; i++)
        vtab[i] <= '0;
    end
    else if (vt_we)
      vtab[s_q.vt_idx] <= vt_wdata;
  end

  // ==========================================================
  // Assertions
  a_vlan_first: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && frm_ready && s_q.vlan_en |=> s_q.st == S_VLAN)
    else $error("vlan check skipped");
  a_default_vid: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && frm_ready && s_q.vlan_en && (!frm_tagged || frm_vid == '0)
    |=> s_q.vid == $past(pv_frm))
    else $error("default vid not used");
  a_bad_vid_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_VLAN && !vt_hit |=> dec_valid && dec_drop && !tbl_req)
    else $error("invalid vid not dropped");
  a_domain_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_VLAN && vt_hit && !vt_filt
    |=> s_q.forwarding_domain_id == $past(vt_e[VE_FID_LSB +: FID_W]) && s_q.st == S_STA)
    else $error("domain id not fetched");
  a_port_filter: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_VLAN && vt_filt |=> dec_drop && dec_ports == '0)
    else $error("filtered frame passed");
  a_flood_members: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_DDA && tbl_ack && !s_q.sta_ok && !tbl_hit |=> s_q.ports == s_q.members)
    else $error("flood mask wrong");
  a_dyn_forward: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_DDA && tbl_ack && !s_q.sta_ok && tbl_hit
    |=> s_q.ports == onehot($past(tbl_dyn_port)))
    else $error("dynamic port wrong");
  a_static_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_DDA && tbl_ack && s_q.sta_ok |=> s_q.ports == $past(s_q.sta_ports))
    else $error("static ports wrong");
  a_learn_new: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_DSA && tbl_ack && !tbl_hit |=> tbl_req && tbl_op == OP_LEARN)
    else $error("missing learn");
  a_refresh: assert property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_DSA && tbl_ack && tbl_hit |=> tbl_req && tbl_op == OP_REFRESH)
    else $error("missing refresh");
  a_no_vlan: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && frm_ready && !s_q.vlan_en |=> s_q.st == S_STA && !s_q.drop)
    else $error("vlan applied while off");
  a_learn_first: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(dec_valid) && !dec_drop |-> $past(s_q.st == S_LRN))
    else $error("decision before learning");
  c_flood: cover property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == S_DDA && tbl_ack && !s_q.sta_ok && !tbl_hit);
  c_drop: cover property (@(posedge aclk) disable iff (!aresetn)
    dec_valid && dec_ready && dec_drop);
  c_learn: cover property (@(posedge aclk) disable iff (!aresetn)
    tbl_req && tbl_ack && tbl_op == OP_LEARN);

endmodule // vfl_lookup
`default_nettype wire

// >>> inc/vfl_pkg.sv
`default_nettype none
package vfl_pkg;
  // ==========================================================
  // Sizes
  localparam int NPORT    = 5;
  localparam int VID_W    = 12;
  localparam int FID_W    = 7;
  localparam int MAC_W    = 48;
  localparam int VT_DEPTH = 128;
  localparam int VT_AW    = 7;
  localparam int CNT_W    = 16;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_GCTRL   = 8'h00;
  localparam logic [7:0] A_VT_IDX  = 8'h04;
  localparam logic [7:0] A_VT_DATA = 8'h08;
  localparam logic [7:0] A_STAT    = 8'h0C;
  localparam logic [7:0] A_PCTRL2  = 8'h20;
  localparam logic [7:0] A_PORT_DEFAULT_VLAN_ID    = 8'h40;
  // ==========================================================
  // Field positions
  localparam int GC_VLAN_EN  = 7;
  localparam int PC_INFILT   = 6;
  localparam int PC_NONPVID  = 5;
  localparam int VE_FID_LSB  = 0;
  localparam int VE_MEM_LSB  = 7;
  localparam int VE_VALID    = 12;
  localparam int VE_VHI_LSB  = 13;
  localparam int VE_W        = 18;
  // ==========================================================
  // Reset values and answers
  localparam logic             VLAN_EN_RST = 1'b0;
  localparam logic [VID_W-1:0] PORT_DEFAULT_VLAN_ID_RST    = 12'h001;
  localparam logic [1:0]       PFLT_RST    = 2'h0;
  localparam logic [1:0]       RESP_OKAY   = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;
  // ==========================================================
  // Table operations and states
  typedef enum logic [2:0] {
    OP_STA     = 3'h0,
    OP_DYN_DA  = 3'h1,
    OP_DYN_SA  = 3'h2,
    OP_LEARN   = 3'h3,
    OP_REFRESH = 3'h4
  } vfl_op_e;
  typedef enum logic [2:0] {
    S_IDLE, S_VLAN, S_STA, S_DDA, S_DSA, S_LRN, S_OUT
  } vfl_state_e;
endpackage
`default_nettype wire

// >>> tb/vfl_tbl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// MAC table stand-in, answer delay set per frame
module vfl_tbl_model
  import vfl_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             tbl_req,
  input  wire vfl_op_e          tbl_op,
  output logic                  tbl_ack,
  output logic                  tbl_hit,
  output logic [NPORT-1:0]      tbl_sta_ports,
  output logic                  tbl_sta_use_fid,
  output logic [FID_W-1:0]      tbl_sta_fid,
  output logic [2:0]            tbl_dyn_port,
  input  wire logic [1:0]       c_dly,
  input  wire logic [2:0]       c_hit,
  input  wire logic [NPORT-1:0] c_ports,
  input  wire logic             c_use,
  input  wire logic [FID_W-1:0] c_fid,
  input  wire logic [2:0]       c_dport
);
  logic [1:0] wt_q;
  logic       tg_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wt_q <= 2'h0;
      tg_q <= 1'b0;
    end
    else
    begin
      tg_q <= ~tg_q;
      wt_q <= (tbl_ack || !tbl_req) ? 2'h0 : wt_q + 2'h1;
    end
  end
  assign tbl_ack = tbl_req && (wt_q == c_dly);
  // Off-ack fields toggle so stale data never looks valid
  always_comb
  begin
    tbl_hit         = tg_q;
    tbl_sta_ports   = {NPORT{tg_q}};
    tbl_sta_use_fid = tg_q;
    tbl_sta_fid     = {FID_W{tg_q}};
    tbl_dyn_port    = {3{tg_q}};
    if (tbl_ack)
    begin
      tbl_hit         = (tbl_op == OP_STA) ? c_hit[0]
                      : (tbl_op == OP_DYN_DA) ? c_hit[1] : c_hit[2];
      tbl_sta_ports   = c_ports;
      tbl_sta_use_fid = c_use;
      tbl_sta_fid     = c_fid;
      tbl_dyn_port    = c_dport;
    end
  end
endmodule // vfl_tbl_model
`default_nettype wire

// >>> tb/vfl_lookup_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vfl_lookup_tb
  import vfl_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, d;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, r, c_dly;
  logic frm_valid, frm_ready, frm_tagged, tbl_req, tbl_ack, tbl_hit, tbl_sta_use_fid;
  logic dec_valid, dec_ready, dec_drop, c_use;
  logic [2:0]       frm_port, tbl_port, tbl_dyn_port, c_hit, c_dport, e_pt, pt;
  logic [VID_W-1:0] frm_vid, vid;
  logic [MAC_W-1:0] frm_da, frm_sa, tbl_mac, e_da, e_sa;
  vfl_op_e          tbl_op;
  logic [FID_W-1:0] tbl_fid, tbl_sta_fid, c_fid, e_fid, forwarding_domain_id;
  logic [NPORT-1:0] tbl_sta_ports, dec_ports, c_ports, mem;
  logic [11:0]      ops;
  int nops, seed, fail_count, num_checks, fwd_n, drp_n;

  vfl_lookup DUT (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .frm_valid, .frm_ready, .frm_port,
    .frm_tagged, .frm_vid, .frm_da, .frm_sa, .tbl_req, .tbl_op, .tbl_mac, .tbl_fid,
    .tbl_port, .tbl_ack, .tbl_hit, .tbl_sta_ports, .tbl_sta_use_fid, .tbl_sta_fid,
    .tbl_dyn_port, .dec_valid, .dec_ready, .dec_drop, .dec_ports);
  vfl_tbl_model PTN (.aclk, .aresetn, .tbl_req, .tbl_op, .tbl_ack, .tbl_hit,
    .tbl_sta_ports, .tbl_sta_use_fid, .tbl_sta_fid, .tbl_dyn_port, .c_dly, .c_hit,
    .c_ports, .c_use, .c_fid, .c_dport);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ========================================
  // Reporting
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [47:0] s, input logic [47:0] e, input string w);
    num_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %0t %s seen %h want %h", $time, w, s, e);
    end
  endtask
  task automatic tmo();
    fail_count++;
    $display("BAD %0t wait limit", $time);
    finish_test();
  endtask
  // ========================================
  // Register bus; each task first lets an edge pass so no signal is set twice
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      n++;
      if (n > 200)
        tmo();
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      n++;
      if (n > 200)
        tmo();
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e, "reg");
    chk(r, RESP_OKAY, "resp");
  endtask
  task automatic ent(input logic [11:0] v, input logic [4:0] hi, input logic ok,
                     input logic [6:0] f, input logic [4:0] mb);
    wr(A_VT_IDX, {25'h0, v[6:0]}, r);
    wr(A_VT_DATA, {14'h0, hi, ok, mb, f}, r);
  endtask
  // ========================================
  // Expectations
  function automatic logic [2:0] rport();
    return 3'(($random(seed) & 32'hFFFF) % 5);
  endfunction
  function automatic logic [4:0] fwd(input logic [2:0] h, input logic u, input logic m,
                                     input logic [4:0] sp, input logic [2:0] dp,
                                     input logic [4:0] mb);
    if (h[0] && (!u || m))
      return sp;
    if (h[1])
      return (dp < 3'h5) ? 5'h01 << dp : 5'h00;
    return mb;
  endfunction
  // ========================================
  // Frame path; k picks the static/dynamic table case
  always @(posedge aclk)
    dec_ready <= 1'($random(seed));
  always @(posedge aclk)
  begin
    if (tbl_req && tbl_ack)
    begin
      ops = {ops[8:0], tbl_op};
      nops++;
      chk(tbl_fid, e_fid, "fid");
      chk(tbl_mac, (tbl_op < OP_DYN_SA) ? e_da : e_sa, "mac");
      if (tbl_op == OP_LEARN)
        chk(tbl_port, e_pt, "learn port");
    end
  end
  task automatic run(input int k, input logic [2:0] p, input logic tg, input logic [11:0] v,
                     input logic [6:0] f, input logic [4:0] mb, input logic drop);
    logic [2:0] h, dp;
    logic [4:0] sp;
    logic       u, m;
    int         n;
    h = 3'($random(seed));
    h[0] = (k >= 2);
    if (k == 0 || k == 3)
      h[1] = 1'b0;
    if (k == 1 || k == 4)
      h[1] = 1'b1;
    u = (k >= 3);
    m = (k == 5);
    sp = 5'($random(seed));
    dp = 3'($random(seed));
    e_da = MAC_W'({$random(seed), $random(seed)});
    e_sa = MAC_W'({$random(seed), $random(seed)});
    @(posedge aclk);
    e_pt = p;
    e_fid = f;
    ops = 12'h0;
    nops = 0;
    c_hit <= h;
    c_use <= u;
    c_ports <= sp;
    c_fid <= m ? f : ~f;
    c_dport <= dp;
    c_dly <= 2'($random(seed));
    frm_valid <= 1'b1;
    frm_port <= p;
    frm_tagged <= tg;
    frm_vid <= v;
    frm_da <= e_da;
    frm_sa <= e_sa;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 200)
        tmo();
    end while (!(frm_valid && frm_ready));
    frm_valid <= 1'b0;
    frm_vid <= ~v;
    frm_da <= ~e_da;
    do
    begin
      @(posedge aclk);
      n++;
      if (n > 400)
        tmo();
    end while (!(dec_valid && dec_ready));
    chk(dec_drop, drop, "drop");
    chk(dec_ports, drop ? 5'h00 : fwd(h, u, m, sp, dp, mb), "ports");
    chk(nops, drop ? 0 : 4, "op count");
    if (!drop)
      chk(ops, {3'h0, 3'h1, 3'h2, h[2] ? 3'h4 : 3'h3}, "op order");
    if (drop)
      drp_n++;
    else
      fwd_n++;
  endtask
  // ========================================
  // Main sequence
  initial
  begin
    seed = 81;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, frm_valid, frm_tagged} = '0;
    {frm_port, frm_vid, frm_da, frm_sa, c_dly, c_hit, c_ports} = '0;
    {c_use, c_fid, c_dport, e_da, e_sa, e_fid, e_pt, ops} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(A_GCTRL, 32'h0);
    for (int p = 0; p < 5; p++)
    begin
      rchk(A_PORT_DEFAULT_VLAN_ID + 8'(4 * p), 32'h1);
      rchk(A_PCTRL2 + 8'(4 * p), 32'h0);
    end
    rd(8'h60, d, r);
    chk({r, d}, {RESP_SLVERR, 32'h0}, "unmapped read");
    wr(8'h64, 32'hFFFF_FFFF, r);
    chk(r, RESP_SLVERR, "unmapped write");
    $display("reset test done");
    for (int i = 0; i < 8; i++)
      run(i % 3, rport(), 1'b1, 12'($random(seed)), 7'h0, 5'h1F, 1'b0);
    $display("vlan off test done");
    wr(A_GCTRL, 32'h80, r);
    for (int i = 0; i < 30; i++)
    begin
      vid = 12'($random(seed)) | 12'h001;
      forwarding_domain_id = 7'($random(seed));
      mem = 5'($random(seed));
      pt = rport();
      ent(vid, vid[11:7], 1'b1, forwarding_domain_id, mem);
      run(i % 6, pt, 1'b1, vid, forwarding_domain_id, mem, 1'b0);
    end
    $display("table case test done");
    ent(vid, ~vid[11:7], 1'b1, forwarding_domain_id, mem);
    run(0, pt, 1'b1, vid, forwarding_domain_id, mem, 1'b1);
    ent(vid, vid[11:7], 1'b0, forwarding_domain_id, mem);
    run(2, pt, 1'b1, vid, forwarding_domain_id, mem, 1'b1);
    ent(vid, vid[11:7], 1'b1, forwarding_domain_id, mem);
    wr(A_PORT_DEFAULT_VLAN_ID + 8'(4 * pt), {20'h0, vid}, r);
    run(0, pt, 1'b0, ~vid, forwarding_domain_id, mem, 1'b0);
    run(3, pt, 1'b1, 12'h000, forwarding_domain_id, mem, 1'b0);
    $display("invalid and default vid test done");
    ent(vid, vid[11:7], 1'b1, forwarding_domain_id, mem & ~(5'h01 << pt));
    wr(A_PCTRL2 + 8'(4 * pt), 32'h40, r);
    run(0, pt, 1'b1, vid, forwarding_domain_id, mem, 1'b1);
    ent(vid, vid[11:7], 1'b1, forwarding_domain_id, mem | (5'h01 << pt));
    run(0, pt, 1'b1, vid, forwarding_domain_id, mem | (5'h01 << pt), 1'b0);
    ent(vid ^ 12'h001, vid[11:7], 1'b1, forwarding_domain_id, mem);
    wr(A_PCTRL2 + 8'(4 * pt), 32'h20, r);
    run(1, pt, 1'b1, vid ^ 12'h001, forwarding_domain_id, mem, 1'b1);
    run(4, pt, 1'b1, vid, forwarding_domain_id, mem, 1'b0);
    wr(A_PCTRL2 + 8'(4 * pt), 32'h0, r);
    rchk(A_STAT, {16'(drp_n), 16'(fwd_n)});
    wr(A_STAT, 32'h0, r);
    rchk(A_STAT, 32'h0);
    $display("filter and count test done");
    finish_test();
  end
endmodule // vfl_lookup_tb
`default_nettype wire
